// file: pkg/i2c_ctl_pkg.sv
package i2c_ctl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int         ADDR_W     = 6;
  localparam logic [5:0] OFS_CONSET = 6'h00;
  localparam logic [5:0] OFS_STAT   = 6'h04;
  localparam logic [5:0] OFS_DATA   = 6'h08;
  localparam logic [5:0] OFS_ADR0   = 6'h0c;
  localparam logic [5:0] OFS_SCLH   = 6'h10;
  localparam logic [5:0] OFS_SCLL   = 6'h14;
  localparam logic [5:0] OFS_CONCLR = 6'h18;
  localparam logic [5:0] OFS_MMCTRL = 6'h1c;
  localparam logic [5:0] OFS_ADR1   = 6'h20;
  localparam logic [5:0] OFS_ADR2   = 6'h24;
  localparam logic [5:0] OFS_ADR3   = 6'h28;

  ////////////////////////////////////////////////////////////////////////////
  localparam int         CB_AA    = 2;
  localparam int         CB_SI    = 3;
  localparam int         CB_STOP  = 4;
  localparam int         CB_START = 5;
  localparam int         CB_EN    = 6;
  localparam logic [6:0] CON_MASK = 7'h7c;
  localparam int         MM_ENA   = 0;
  localparam int         MM_ALL   = 2;
  localparam logic [3:0] BIT_ACK  = 4'h8;
  localparam logic [3:0] BIT_END  = 4'h9;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [6:0]  RST_CON     = 7'h00;
  localparam logic [7:0]  RST_STAT    = 8'hf8;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [15:0] RST_SCL_CNT = 16'h0004;
  localparam logic [2:0]  RST_MM      = 3'h0;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] SC_START    = 8'h08;
  localparam logic [7:0] SC_RSTART   = 8'h10;
  localparam logic [7:0] SC_AW_ACK   = 8'h18;
  localparam logic [7:0] SC_AW_NACK  = 8'h20;
  localparam logic [7:0] SC_TX_ACK   = 8'h28;
  localparam logic [7:0] SC_TX_NACK  = 8'h30;
  localparam logic [7:0] SC_ARB      = 8'h38;
  localparam logic [7:0] SC_AR_ACK   = 8'h40;
  localparam logic [7:0] SC_AR_NACK  = 8'h48;
  localparam logic [7:0] SC_RX_ACK   = 8'h50;
  localparam logic [7:0] SC_RX_NACK  = 8'h58;
  localparam logic [7:0] SC_SW_ACK   = 8'h60;
  localparam logic [7:0] SC_GC_ACK   = 8'h70;
  localparam logic [7:0] SC_SRX_ACK  = 8'h80;
  localparam logic [7:0] SC_SRX_NACK = 8'h88;
  localparam logic [7:0] SC_SSTOP    = 8'ha0;
  localparam logic [7:0] SC_SR_ACK   = 8'ha8;
  localparam logic [7:0] SC_STX_ACK  = 8'hb8;
  localparam logic [7:0] SC_STX_NACK = 8'hc0;
  localparam logic [7:0] SC_IDLE     = 8'hf8;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [2:0] {
    PH_IDLE, PH_START, PH_START_HOLD, PH_LOW, PH_HIGH, PH_STOP, PH_SLAVE
  } phase_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } av_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } av_rsp_t;

  typedef struct packed {
    logic scl_out;
    logic scl_oe;
    logic sda_out;
    logic sda_oe;
  } pin_out_t;

  typedef struct packed {
    av_rsp_t         rsp;
    pin_out_t        pins;
    logic [6:0]      con;
    logic [7:0]      stat;
    logic [7:0]      data;
    logic [3:0][7:0] adr;
    logic [15:0]     sclh;
    logic [15:0]     scll;
    logic [2:0]      mm;
    logic            scl_s1;
    logic            scl_s2;
    logic            scl_p;
    logic            sda_s1;
    logic            sda_s2;
    logic            sda_p;
    logic            busy;
    phase_t          ph;
    logic            master;
    logic            rs;
    logic            tx;
    logic            addr_ph;
    logic            addressed;
    logic            sent;
    logic            ld;
    logic            nack;
    logic [3:0]      bits;
    logic [7:0]      shift;
    logic [15:0]     cnt;
  } state_t;

  localparam state_t STATE_RST = '{
    rsp: '{readdata: 32'h0, waitrequest: 1'b1},
    pins: '{scl_out: 1'b0, scl_oe: 1'b0, sda_out: 1'b0, sda_oe: 1'b0},
    con: RST_CON, stat: RST_STAT, data: RST_BYTE,
    adr: {4{RST_BYTE}}, sclh: RST_SCL_CNT, scll: RST_SCL_CNT, mm: RST_MM,
    scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
    busy: 1'b0, ph: PH_IDLE, master: 1'b0, rs: 1'b0, tx: 1'b0,
    addr_ph: 1'b0, addressed: 1'b0, sent: 1'b0, ld: 1'b0, nack: 1'b0,
    bits: 4'h0, shift: 8'h00, cnt: 16'h0000
  };

endpackage

// file: src/i2c_bus_controller.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_controller (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst,
  // Register bus
  input  wire i2c_ctl_pkg::av_req_t  av_req,
  output var  i2c_ctl_pkg::av_rsp_t  av_rsp,
  // Two-wire bus lines
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output var  i2c_ctl_pkg::pin_out_t pins
);
  import i2c_ctl_pkg::*;

  state_t s_r;
  state_t s_nxt;
  logic   scl;
  logic   sda;
  logic   start_det;
  logic   stop_det;
  logic   rise;
  logic   fall;
  logic   mon;
  logic   match;
  logic   gc;
  logic   gc_en;
  logic   [6:0] wd;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic elapsed(input logic [15:0] c, input logic [15:0] lim);
    return c >= lim;
  endfunction

  function automatic logic adr_hit(input logic [7:0] own, input logic [7:0] rx);
    return own[7:1] == rx[7:1];
  endfunction

  assign scl       = s_r.scl_s2;
  assign sda       = s_r.sda_s2;
  assign start_det = s_r.scl_p && scl && s_r.sda_p && !sda;
  assign stop_det  = s_r.scl_p && scl && !s_r.sda_p && sda;
  assign rise      = scl && !s_r.scl_p;
  assign fall      = !scl && s_r.scl_p;
  assign mon       = s_r.mm[MM_ENA];
  assign wd        = av_req.writedata[6:0];

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt = s_r;
    match = s_r.mm[MM_ALL];
    gc    = s_r.shift[7:1] == 7'h00;
    gc_en = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (adr_hit(s_r.adr[i], s_r.shift)) begin
        match = 1'b1;
      end
      if (gc && s_r.adr[i][0]) begin
        gc_en = 1'b1;
      end
    end
    match = match || gc_en;

    // Input synchronisers
    s_nxt.scl_s1 = scl_in;
    s_nxt.scl_s2 = s_r.scl_s1;
    s_nxt.scl_p  = s_r.scl_s2;
    s_nxt.sda_s1 = sda_in;
    s_nxt.sda_s2 = s_r.sda_s1;
    s_nxt.sda_p  = s_r.sda_s2;

    // Register bus: answer one cycle after the request is seen
    s_nxt.rsp.waitrequest = 1'b1;
    if ((av_req.read || av_req.write) && s_r.rsp.waitrequest) begin
      s_nxt.rsp.waitrequest = 1'b0;
      case (av_req.address)
        OFS_CONSET: s_nxt.rsp.readdata = {25'h0, s_r.con};
        OFS_STAT:   s_nxt.rsp.readdata = {24'h0, s_r.stat};
        OFS_DATA:   s_nxt.rsp.readdata = {24'h0, s_r.data};
        OFS_ADR0:   s_nxt.rsp.readdata = {24'h0, s_r.adr[0]};
        OFS_ADR1:   s_nxt.rsp.readdata = {24'h0, s_r.adr[1]};
        OFS_ADR2:   s_nxt.rsp.readdata = {24'h0, s_r.adr[2]};
        OFS_ADR3:   s_nxt.rsp.readdata = {24'h0, s_r.adr[3]};
        OFS_SCLH:   s_nxt.rsp.readdata = {16'h0, s_r.sclh};
        OFS_SCLL:   s_nxt.rsp.readdata = {16'h0, s_r.scll};
        OFS_MMCTRL: s_nxt.rsp.readdata = {29'h0, s_r.mm};
        default:    s_nxt.rsp.readdata = 32'h0;
      endcase
    end
    if (av_req.write && !s_r.rsp.waitrequest) begin
      case (av_req.address)
        OFS_CONSET: s_nxt.con = s_r.con | (wd & CON_MASK);
        OFS_CONCLR: s_nxt.con = s_r.con & ~(wd & CON_MASK);
        OFS_DATA:   s_nxt.data = av_req.writedata[7:0];
        OFS_ADR0:   s_nxt.adr[0] = av_req.writedata[7:0];
        OFS_ADR1:   s_nxt.adr[1] = av_req.writedata[7:0];
        OFS_ADR2:   s_nxt.adr[2] = av_req.writedata[7:0];
        OFS_ADR3:   s_nxt.adr[3] = av_req.writedata[7:0];
        OFS_SCLH:   s_nxt.sclh = av_req.writedata[15:0];
        OFS_SCLL:   s_nxt.scll = av_req.writedata[15:0];
        OFS_MMCTRL: s_nxt.mm = av_req.writedata[2:0];
        default:    s_nxt.mm = s_r.mm;
      endcase
    end

    // Bus occupancy; hardware updates below win over software writes
    if (start_det) begin
      s_nxt.busy = 1'b1;
    end
    if (stop_det) begin
      s_nxt.busy         = 1'b0;
      s_nxt.con[CB_STOP] = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    if (!s_nxt.con[CB_EN]) begin
      s_nxt.ph          = PH_IDLE;
      s_nxt.master      = 1'b0;
      s_nxt.addressed   = 1'b0;
      s_nxt.busy        = 1'b0;
      s_nxt.con[CB_STOP] = 1'b0;
      s_nxt.pins.scl_oe = 1'b0;
      s_nxt.pins.sda_oe = 1'b0;
    end else begin
      unique case (s_r.ph)
        PH_IDLE: begin
          s_nxt.pins.scl_oe = 1'b0;
          s_nxt.pins.sda_oe = 1'b0;
          s_nxt.con[CB_STOP] = 1'b0;
          if (s_nxt.con[CB_START] && !s_r.busy && !s_nxt.con[CB_SI]) begin
            s_nxt.ph     = PH_START;
            s_nxt.master = 1'b1;
            s_nxt.rs     = 1'b0;
            s_nxt.cnt    = 16'h0000;
          end else if (start_det) begin
            s_nxt.ph        = PH_SLAVE;
            s_nxt.bits      = 4'h0;
            s_nxt.addr_ph   = 1'b1;
            s_nxt.addressed = 1'b0;
            s_nxt.tx        = 1'b0;
          end
        end

        PH_START: begin
          s_nxt.pins.scl_oe = 1'b0;
          if (scl) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (elapsed(s_r.cnt, s_r.sclh)) begin
              s_nxt.pins.sda_oe = 1'b1;
              s_nxt.cnt         = 16'h0000;
              s_nxt.ph          = PH_START_HOLD;
            end
          end
        end

        PH_START_HOLD: begin
          s_nxt.cnt = s_r.cnt + 16'h0001;
          if (elapsed(s_r.cnt, s_r.sclh)) begin
            s_nxt.pins.scl_oe = 1'b1;
            s_nxt.stat        = s_r.rs ? SC_RSTART : SC_START;
            s_nxt.con[CB_SI]  = 1'b1;
            s_nxt.ph          = PH_LOW;
            s_nxt.bits        = 4'h0;
            s_nxt.addr_ph     = 1'b1;
            s_nxt.tx          = 1'b1;
            s_nxt.ld          = 1'b1;
            s_nxt.cnt         = 16'h0000;
          end
        end

        PH_LOW: begin
          s_nxt.pins.scl_oe = 1'b1;
          if (!s_nxt.con[CB_SI]) begin
            if (s_r.ld) begin
              s_nxt.ld = 1'b0;
              if (s_nxt.con[CB_STOP] && !s_r.addr_ph) begin
                s_nxt.pins.sda_oe = 1'b1;
                s_nxt.ph          = PH_STOP;
                s_nxt.bits        = 4'h0;
                s_nxt.cnt         = 16'h0000;
              end else if (s_nxt.con[CB_START] && !s_r.addr_ph) begin
                s_nxt.pins.sda_oe = 1'b0;
                s_nxt.ph          = PH_START;
                s_nxt.rs          = 1'b1;
                s_nxt.cnt         = 16'h0000;
              end else if (s_r.tx) begin
                s_nxt.shift = s_r.data;
              end
            end else begin
              if (s_r.bits == BIT_ACK) begin
                s_nxt.pins.sda_oe = !s_r.tx && s_nxt.con[CB_AA];
              end else begin
                s_nxt.pins.sda_oe = s_r.tx && !s_r.shift[7];
              end
              s_nxt.cnt = s_r.cnt + 16'h0001;
              if (elapsed(s_r.cnt, s_r.scll)) begin
                s_nxt.ph  = PH_HIGH;
                s_nxt.cnt = 16'h0000;
              end
            end
          end
        end

        PH_HIGH: begin
          s_nxt.pins.scl_oe = 1'b0;
          if (scl) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
          end
          if (scl && s_r.cnt == 16'h0000) begin
            if (s_r.bits == BIT_ACK) begin
              s_nxt.nack = sda;
            end else begin
              s_nxt.shift = {s_r.shift[6:0], sda};
            end
          end
          if (scl && s_r.cnt == 16'h0000 && s_r.bits != BIT_ACK && s_r.tx && s_r.shift[7] && !sda) begin
            s_nxt.master      = 1'b0;
            s_nxt.stat        = SC_ARB;
            s_nxt.con[CB_SI]  = 1'b1;
            s_nxt.pins.sda_oe = 1'b0;
            s_nxt.ph          = PH_SLAVE;
            s_nxt.addr_ph     = 1'b0;
            s_nxt.addressed   = 1'b0;
          end else if ((scl && elapsed(s_r.cnt, s_r.sclh)) || (!scl && s_r.cnt != 16'h0000)) begin
            s_nxt.cnt         = 16'h0000;
            s_nxt.ph          = PH_LOW;
            s_nxt.pins.scl_oe = 1'b1;
            s_nxt.bits        = s_r.bits + 4'h1;
            if (s_r.bits == BIT_ACK) begin
              s_nxt.bits       = 4'h0;
              s_nxt.ld         = 1'b1;
              s_nxt.con[CB_SI] = 1'b1;
              if (s_r.addr_ph) begin
                s_nxt.addr_ph = 1'b0;
                s_nxt.tx      = !s_r.shift[0];
                if (s_r.shift[0]) begin
                  s_nxt.stat = s_r.nack ? SC_AR_NACK : SC_AR_ACK;
                end else begin
                  s_nxt.stat = s_r.nack ? SC_AW_NACK : SC_AW_ACK;
                end
              end else if (s_r.tx) begin
                s_nxt.stat = s_r.nack ? SC_TX_NACK : SC_TX_ACK;
              end else begin
                s_nxt.stat = s_r.nack ? SC_RX_NACK : SC_RX_ACK;
                s_nxt.data = s_r.shift;
              end
            end
          end
        end

        PH_STOP: begin
          if (s_r.bits == 4'h0) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (elapsed(s_r.cnt, s_r.scll)) begin
              s_nxt.pins.scl_oe = 1'b0;
              s_nxt.bits        = 4'h1;
              s_nxt.cnt         = 16'h0000;
            end
          end else if (scl) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
            if (elapsed(s_r.cnt, s_r.sclh)) begin
              s_nxt.pins.sda_oe = 1'b0;
              s_nxt.ph          = PH_IDLE;
              s_nxt.master      = 1'b0;
              s_nxt.stat        = SC_IDLE;
              s_nxt.bits        = 4'h0;
            end
          end
        end

        PH_SLAVE: begin
          s_nxt.pins.scl_oe = s_nxt.con[CB_SI] && (s_r.pins.scl_oe || !scl);
          if (s_r.ld && !s_nxt.con[CB_SI] && s_r.tx) begin
            s_nxt.ld    = 1'b0;
            s_nxt.shift = s_r.data;
            if (s_r.bits == 4'h0) begin
              s_nxt.pins.sda_oe = !s_r.data[7] && !mon;
            end
          end
          if (stop_det || s_nxt.con[CB_STOP]) begin
            if (s_r.addressed) begin
              s_nxt.stat       = SC_SSTOP;
              s_nxt.con[CB_SI] = 1'b1;
            end
            s_nxt.ph          = PH_IDLE;
            s_nxt.pins.sda_oe = 1'b0;
            s_nxt.con[CB_STOP] = 1'b0;
            s_nxt.addressed   = 1'b0;
          end else if (start_det) begin
            if (s_r.addressed) begin
              s_nxt.stat       = SC_SSTOP;
              s_nxt.con[CB_SI] = 1'b1;
            end
            s_nxt.bits        = 4'h0;
            s_nxt.addr_ph     = 1'b1;
            s_nxt.addressed   = 1'b0;
            s_nxt.tx          = 1'b0;
            s_nxt.pins.sda_oe = 1'b0;
          end else if (rise) begin
            if (s_r.bits == BIT_ACK) begin
              s_nxt.nack = sda;
            end else begin
              s_nxt.shift = {s_r.shift[6:0], sda};
            end
            s_nxt.bits = s_r.bits + 4'h1;
          end else if (fall && (s_r.addr_ph || s_r.addressed)) begin
            if (s_r.bits == BIT_ACK) begin
              if (s_r.addr_ph) begin
                s_nxt.addr_ph = 1'b0;
                if (match && s_nxt.con[CB_AA]) begin
                  s_nxt.addressed   = 1'b1;
                  s_nxt.tx          = s_r.shift[0];
                  s_nxt.sent        = 1'b0;
                  s_nxt.ld          = s_r.shift[0];
                  s_nxt.pins.sda_oe = !mon;
                  s_nxt.con[CB_SI]  = 1'b1;
                  if (s_r.shift[0]) begin
                    s_nxt.stat = SC_SR_ACK;
                  end else begin
                    s_nxt.stat = gc ? SC_GC_ACK : SC_SW_ACK;
                  end
                end
              end else if (!s_r.tx) begin
                s_nxt.data        = s_r.shift;
                s_nxt.pins.sda_oe = s_nxt.con[CB_AA] && !mon;
                s_nxt.stat        = s_nxt.con[CB_AA] ? SC_SRX_ACK : SC_SRX_NACK;
                s_nxt.con[CB_SI]  = 1'b1;
              end else begin
                s_nxt.pins.sda_oe = 1'b0;
              end
            end else if (s_r.bits == BIT_END) begin
              s_nxt.bits        = 4'h0;
              s_nxt.pins.sda_oe = 1'b0;
              if (s_r.tx && !s_r.sent) begin
                s_nxt.sent        = 1'b1;
                s_nxt.pins.sda_oe = !s_r.shift[7] && !mon;
              end else if (s_r.tx && s_r.nack) begin
                s_nxt.stat       = SC_STX_NACK;
                s_nxt.con[CB_SI] = 1'b1;
                s_nxt.addressed  = 1'b0;
              end else if (s_r.tx) begin
                s_nxt.stat       = SC_STX_ACK;
                s_nxt.con[CB_SI] = 1'b1;
                s_nxt.ld         = 1'b1;
              end
            end else if (s_r.tx && s_r.addressed && s_r.bits != 4'h0) begin
              s_nxt.pins.sda_oe = !s_r.shift[7] && !mon;
            end
          end
        end

        default: begin
          s_nxt.ph = PH_IDLE;
        end
      endcase
    end
    s_nxt.pins.scl_out = 1'b0;
    s_nxt.pins.sda_out = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= STATE_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign av_rsp = s_r.rsp;
  assign pins   = s_r.pins;

endmodule // i2c_bus_controller
`default_nettype wire

// file: sim/i2c_bus_controller_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_controller_monitor (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Register bus
  input wire i2c_ctl_pkg::av_req_t  av_req,
  input wire i2c_ctl_pkg::av_rsp_t  av_rsp,
  // Two-wire bus lines
  input wire logic                  scl_in,
  input wire logic                  sda_in,
  input wire i2c_ctl_pkg::pin_out_t pins
);
  import i2c_ctl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic rd_ack;
  assign rd_ack = !av_rsp.waitrequest && av_req.read;
  ////////////////////////////////////////////////////////////////////////////
  property p_rst; $fell(rst) |-> av_rsp.waitrequest && !pins.scl_oe && !pins.sda_oe; endproperty
  property p_drv; pins.scl_out == 1'b0 && pins.sda_out == 1'b0; endproperty
  property p_ans; (av_req.read || av_req.write) && av_rsp.waitrequest |=> !av_rsp.waitrequest; endproperty
  property p_one; !av_rsp.waitrequest |=> av_rsp.waitrequest; endproperty
  property p_idle; av_rsp.waitrequest && !av_req.read && !av_req.write |=> av_rsp.waitrequest; endproperty
  property p_clr; rd_ack && av_req.address == OFS_CONCLR |-> av_rsp.readdata == 32'h0; endproperty
  property p_con; rd_ack && av_req.address == OFS_CONSET |-> av_rsp.readdata[31:7] == '0 && !av_rsp.readdata[1:0];
  endproperty
  property p_stat; rd_ack && av_req.address == OFS_STAT |-> av_rsp.readdata[31:8] == '0 && !av_rsp.readdata[2:0];
  endproperty
  property p_hi; $fell(pins.scl_oe) |-> !pins.scl_oe [*5]; endproperty
  property p_lo; $rose(pins.scl_oe) |-> pins.scl_oe [*3]; endproperty
  a_rst: assert property (p_rst) else $error("outputs not at reset level");
  a_drv: assert property (p_drv) else $error("line driven high");
  a_ans: assert property (p_ans) else $error("access not answered");
  a_one: assert property (p_one) else $error("answer longer than one cycle");
  a_idle: assert property (p_idle) else $error("answer without request");
  a_clr: assert property (p_clr) else $error("clear port read not zero");
  a_con: assert property (p_con) else $error("reserved control bits set");
  a_stat: assert property (p_stat) else $error("bad status code form");
  a_hi: assert property (p_hi) else $error("clock high time too short");
  a_lo: assert property (p_lo) else $error("clock low time too short");
  c_start: cover property ($rose(pins.sda_oe) && scl_in);
  c_stop: cover property ($fell(pins.sda_oe) && scl_in);
  c_held: cover property (!pins.scl_oe && !scl_in && sda_in);
endmodule // i2c_bus_controller_monitor
bind i2c_bus_controller i2c_bus_controller_monitor i2c_bus_controller_monitor_i (
  .clk(clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp), .scl_in(scl_in), .sda_in(sda_in), .pins(pins));
`default_nettype wire

// file: sim/i2c_target_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_target_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  // Bus lines
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       slow,
  output var  logic       scl_pull,
  output var  logic       sda_pull,
  // Seen traffic
  output var  logic [7:0] got,
  output var  logic [1:0] acks
);
  logic [7:0] sh;
  logic [7:0] tx;
  logic       rd;
  logic       hit;
  logic       nak;
  int         n = -1;
  int         b = 0;
  initial {scl_pull, sda_pull, got, acks, sh, tx, rd, hit, nak} = '0;
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge sda) if (scl) begin
    n = 8;
    b = -1;
    nak = 1'b0;
  end
  always @(posedge sda) if (scl) n = -1;
  always @(posedge scl) if (n >= 0) begin
    if (n < 8) sh = {sh[6:0], sda};
    if (n == 8 && rd && b > 0) begin
      nak = sda;
      acks = {acks[0], sda};
    end
  end
  always @(negedge scl) if (n >= 0) begin
    n = (n == 8) ? 0 : n + 1;
    if (n == 0) b = b + 1;
    if (n == 8 && b == 0) begin
      hit = sh[7:1] == ADDR;
      rd = sh[0];
    end
    if (n == 8 && b > 0 && !rd) got = sh;
    tx = 8'hc3 ^ 8'(b);
    sda_pull = hit && (n == 8 ? (b == 0 || !rd) : (rd && b > 0 && !nak && !tx[7 - n]));
    if (n == 8 && slow) begin
      scl_pull = 1'b1;
      #160;
      scl_pull = 1'b0;
    end
  end
endmodule // i2c_target_model
`default_nettype wire

// file: sim/i2c_bus_controller_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_controller_tb_top;
  import i2c_ctl_pkg::*;
  localparam logic [6:0] TGT = 7'h2a;
  logic        clk;
  logic        rst;
  logic        slow;
  av_req_t     av_req;
  av_rsp_t     av_rsp;
  pin_out_t    pins;
  logic        scl_pull;
  logic        sda_pull;
  logic        m_scl = 1'b0;
  logic        m_sda = 1'b0;
  logic        scl;
  logic        sda;
  logic [7:0]  got;
  logic [1:0]  acks;
  int          fails = 0;
  int          compares = 0;
  int          cycles = 0;
  logic [5:0]  ra [7] = '{OFS_STAT, OFS_SCLH, OFS_SCLL, OFS_ADR1, OFS_CONCLR, 6'h3c, OFS_DATA};
  logic [31:0] rv [7] = '{32'hf8, 32'h4, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0};
  logic [31:0] wv [7] = '{32'hff, 32'h6, 32'h5, 32'h5a, 32'hff, 32'hff, 32'h1a5};
  logic [31:0] ev [7] = '{32'hf8, 32'h6, 32'h5, 32'h5a, 32'h0, 32'h0, 32'ha5};
  assign scl = !pins.scl_oe && !scl_pull && !m_scl;
  assign sda = !pins.sda_oe && !sda_pull && !m_sda;
  i2c_bus_controller i2c_bus_controller_i (.clk(clk), .rst(rst), .av_req(av_req), .av_rsp(av_rsp),
    .scl_in(scl), .sda_in(sda), .pins(pins));
  i2c_target_model #(.ADDR(TGT)) i2c_target_model_i (.scl(scl), .sda(sda), .slow(slow), .scl_pull(scl_pull),
    .sda_pull(sda_pull), .got(got), .acks(acks));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      fails = fails + 1;
      wrap_up;
    end
  end
  task automatic wrap_up;
    $display("Checks %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    av_req <= '{read: !wr, write: wr, address: a, writedata: d};
    do
      @(posedge clk);
    while (av_rsp.waitrequest !== 1'b0);
    q = av_rsp.readdata;
    av_req <= '0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    acc(1'b1, a, d, q);
  endtask
  task automatic mbit(input logic b);
    m_sda <= !b;
    repeat (8) @(posedge clk);
    m_scl <= 1'b0;
    repeat (8) @(posedge clk);
    m_scl <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rc(input string s, input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    acc(1'b0, a, 32'h0, q);
    chk(s, e, q);
  endtask
  task automatic step(input logic [31:0] clr, input logic [7:0] code);
    logic [31:0] q;
    wr(OFS_CONCLR, clr);
    q = 32'h0;
    while (q[CB_SI] !== 1'b1) acc(1'b0, OFS_CONSET, 32'h0, q);
    rc("status", OFS_STAT, {24'h0, code});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    av_req = '0;
    rst = 1'b1;
    slow = 1'b1;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 7; i++) begin
      rc("reset value", ra[i], rv[i]);
      wr(ra[i], wv[i]);
      rc("readback", ra[i], ev[i]);
    end
    wr(OFS_CONSET, 32'h44);
    wr(OFS_CONCLR, 32'h04);
    rc("control", OFS_CONSET, 32'h40);
    $display("test registers done");
    wr(OFS_DATA, {24'h0, TGT, 1'b0});
    wr(OFS_CONSET, 32'h20);
    step(32'h0, SC_START);
    step(32'h28, SC_AW_ACK);
    wr(OFS_DATA, 32'h96);
    step(32'h08, SC_TX_ACK);
    chk("target byte", 32'h96, {24'h0, got});
    $display("test master write done");
    slow <= 1'b0;
    wr(OFS_CONSET, 32'h20);
    step(32'h08, SC_RSTART);
    wr(OFS_DATA, {24'h0, TGT, 1'b1});
    wr(OFS_CONSET, 32'h04);
    step(32'h28, SC_AR_ACK);
    step(32'h08, SC_RX_ACK);
    rc("rx byte", OFS_DATA, 32'hc2);
    step(32'h0c, SC_RX_NACK);
    rc("rx byte", OFS_DATA, 32'hc1);
    chk("master acks", 32'h1, {30'h0, acks});
    wr(OFS_CONSET, 32'h10);
    wr(OFS_CONCLR, 32'h08);
    q = 32'h0;
    while (q[7:0] !== 8'hf8) acc(1'b0, OFS_STAT, 32'h0, q);
    rc("control", OFS_CONSET, 32'h40);
    $display("test master read done");
    wr(OFS_CONSET, 32'h04);
    m_sda <= 1'b1;
    repeat (8) @(posedge clk);
    m_scl <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 7; i >= 0; i--) mbit(ev[3][i]);
    m_sda <= 1'b0;
    step(32'h0, SC_SW_ACK);
    chk("slave ack", 32'h0, {31'h0, sda});
    wr(OFS_CONCLR, 32'h08);
    mbit(1'b1);
    m_sda <= 1'b1;
    repeat (8) @(posedge clk);
    m_scl <= 1'b0;
    repeat (8) @(posedge clk);
    m_sda <= 1'b0;
    step(32'h0, SC_SSTOP);
    $display("test slave receive done");
    wrap_up;
  end
endmodule // i2c_bus_controller_tb_top
`default_nettype wire
